// File: core/gpit_timer.sv
// Top of the 32-bit general-purpose interval timer with control, period and count registers.
`timescale 1ns/1ns
`default_nettype none
module gpit_timer #(
   parameter int DIV          = gpit_pkg::INT_DIV,
   parameter bit HALT_SUPPORT = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  reg_sel,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   input  wire logic        timer_input_pin,
   output logic             timer_output_pin,
   output logic             timer_irq,
   output logic             timer_dma_evt,
   input  wire logic        emu_halt
);
   gpit_pkg::gpit_ctl_s ctl_ff;
   logic [31:0]         period_ff;
   logic [31:0]         count_ff;
   logic [31:0]         nxt_count;
   logic [31:0]         rdata_ff;
   logic                started_ff;
   logic                status_ff;
   logic [1:0]          width_ff;
   logic                src_prev_ff;
   logic                out_ff;
   logic                pin_lvl;
   logic                div_lvl;
   logic                src_lvl;
   logic                edge_tick;
   logic                halted;
   logic                cnt_en;
   logic                adv;
   logic                hit;
   logic                wr_ctl;
   logic                wr_prd;
   logic                wr_cnt;
   logic                go_start;

   gpit_sync u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (timer_input_pin),
      .dout  (pin_lvl)
   );

   gpit_div #(.DIV(DIV)) u_div (
      .clk   (clk),
      .rst_n (rst_n),
      .lvl   (div_lvl)
   );

   assign wr_ctl   = reg_wr && (reg_sel == gpit_pkg::REG_CTL);
   assign wr_prd   = reg_wr && (reg_sel == gpit_pkg::REG_PRD);
   assign wr_cnt   = reg_wr && (reg_sel == gpit_pkg::REG_CNT);
   // Start only when both start and run are written as one.
   assign go_start = wr_ctl && reg_wdata[gpit_pkg::BIT_GO] && reg_wdata[gpit_pkg::BIT_HLD];

   // Source select and polarity; the internal clock ignores input invert.
   assign src_lvl = ctl_ff.clock_source_select ? div_lvl
                                               : (pin_lvl ^ ctl_ff.input_invert);
   assign edge_tick = src_lvl && !src_prev_ff;
   assign halted    = HALT_SUPPORT && emu_halt && ctl_ff.clock_source_select;
   assign cnt_en    = ctl_ff.count_run && !halted;
   assign adv       = edge_tick && cnt_en;
   assign hit       = started_ff && (count_ff == period_ff);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_ff <= 1'b0;
      end else begin
         src_prev_ff <= src_lvl;
      end
   end

   always_comb begin
      if (wr_cnt) begin
         nxt_count = reg_wdata;
      end else if (go_start) begin
         nxt_count = 32'h0000_0000;
      end else if (cnt_en && hit) begin
         nxt_count = 32'h0000_0000;
      end else if (adv) begin
         nxt_count = count_ff + 32'h0000_0001;
      end else begin
         nxt_count = count_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= gpit_pkg::CNT_RESET;
      end else begin
         count_ff <= nxt_count;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         period_ff <= gpit_pkg::PRD_RESET;
      end else if (wr_prd) begin
         period_ff <= reg_wdata;
      end
   end

   // The start bit is never stored, so it reads back as zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_ff <= gpit_pkg::CTL_RESET;
      end else if (wr_ctl) begin
         ctl_ff.input_invert        <= reg_wdata[gpit_pkg::BIT_INPUT_INVERT];
         ctl_ff.clock_source_select <= reg_wdata[gpit_pkg::BIT_CLOCK_SOURCE_SELECT];
         ctl_ff.clock_pulse_mode    <= reg_wdata[gpit_pkg::BIT_CP];
         ctl_ff.count_run           <= reg_wdata[gpit_pkg::BIT_HLD];
         ctl_ff.pulse_width_select  <= reg_wdata[gpit_pkg::BIT_PULSE_WIDTH_SELECT];
         ctl_ff.output_pin_level    <= reg_wdata[gpit_pkg::BIT_OUTPUT_PIN_LEVEL];
         ctl_ff.output_invert       <= reg_wdata[gpit_pkg::BIT_OUTPUT_INVERT];
         ctl_ff.output_pin_function <= reg_wdata[gpit_pkg::BIT_OUTPUT_PIN_FUNCTION];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         started_ff <= 1'b0;
      end else if (go_start) begin
         started_ff <= 1'b1;
      end
   end

   // Status generation; a control write in the same cycle freezes the update.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= 1'b0;
         width_ff  <= 2'h0;
      end else if (!wr_ctl) begin
         if (ctl_ff.clock_pulse_mode) begin
            width_ff <= 2'h0;
            if (hit && cnt_en) begin
               status_ff <= !status_ff;
            end
         end else if (hit) begin
            // A match that lands as the pulse ends keeps the status high.
            status_ff <= 1'b1;
            width_ff  <= {1'b0, ctl_ff.pulse_width_select} + 2'h1;
         end else if (adv && width_ff != 2'h0) begin
            width_ff <= width_ff - 2'h1;
         end else if (width_ff == 2'h0) begin
            // The pulse ends one clock after its last input edge, one input period wide, or two when pulse_width_select is set.
            status_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= 1'b0;
      end else if (ctl_ff.output_pin_function) begin
         out_ff <= status_ff ^ ctl_ff.output_invert;
      end else begin
         out_ff <= ctl_ff.output_pin_level;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_sel)
            gpit_pkg::REG_CTL: begin
               rdata_ff                       <= 32'h0000_0000;
               rdata_ff[gpit_pkg::BIT_TIMER_STATUS_SIGNAL]  <= status_ff;
               rdata_ff[gpit_pkg::BIT_INPUT_INVERT] <= ctl_ff.input_invert;
               rdata_ff[gpit_pkg::BIT_CLOCK_SOURCE_SELECT] <= ctl_ff.clock_source_select;
               rdata_ff[gpit_pkg::BIT_CP]     <= ctl_ff.clock_pulse_mode;
               rdata_ff[gpit_pkg::BIT_HLD]    <= ctl_ff.count_run;
               rdata_ff[gpit_pkg::BIT_PULSE_WIDTH_SELECT]   <= ctl_ff.pulse_width_select;
               rdata_ff[gpit_pkg::BIT_INPUT_PIN_LEVEL]  <= pin_lvl;
               rdata_ff[gpit_pkg::BIT_OUTPUT_PIN_LEVEL] <= ctl_ff.output_pin_level;
               rdata_ff[gpit_pkg::BIT_OUTPUT_INVERT] <= ctl_ff.output_invert;
               rdata_ff[gpit_pkg::BIT_OUTPUT_PIN_FUNCTION]   <= ctl_ff.output_pin_function;
            end
            gpit_pkg::REG_PRD: rdata_ff <= period_ff;
            gpit_pkg::REG_CNT: rdata_ff <= count_ff;
            default:           rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign reg_rdata        = rdata_ff;
   assign timer_output_pin = out_ff;
   assign timer_irq        = status_ff;
   assign timer_dma_evt    = status_ff;

   a_go_clears: assert property (@(posedge clk) disable iff (!rst_n)
      go_start |=> (count_ff == 32'h0000_0000) && started_ff)
      else $error("start did not clear the counter");

   a_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (cnt_en && hit && !reg_wr) |=> (count_ff == 32'h0000_0000))
      else $error("counter did not return to zero after period match");

   a_step_one: assert property (@(posedge clk) disable iff (!rst_n)
      (adv && !hit && !reg_wr) |=> (count_ff == $past(count_ff) + 32'h0000_0001))
      else $error("counter did not advance by one on an input edge");

   a_hold_count: assert property (@(posedge clk) disable iff (!rst_n)
      (!ctl_ff.count_run && !reg_wr) |=> $stable(count_ff))
      else $error("counter moved while held");

   a_halt_stops: assert property (@(posedge clk) disable iff (!rst_n)
      (halted && !reg_wr) |=> $stable(count_ff))
      else $error("counter moved during emulation halt");

   a_bus_wins: assert property (@(posedge clk) disable iff (!rst_n)
      wr_cnt |=> (count_ff == $past(reg_wdata)))
      else $error("bus write to count was lost");

   a_idle_status: assert property (@(posedge clk) disable iff (!rst_n)
      !started_ff |-> !status_ff)
      else $error("status active before start");

   a_pulse_rise: assert property (@(posedge clk) disable iff (!rst_n)
      (!ctl_ff.clock_pulse_mode && hit && !wr_ctl) |=> status_ff)
      else $error("pulse status did not rise after period match");

   a_clock_flip: assert property (@(posedge clk) disable iff (!rst_n)
      (ctl_ff.clock_pulse_mode && hit && cnt_en && !wr_ctl) |=> (status_ff != $past(status_ff)))
      else $error("clock mode status did not toggle");

   a_pin_drive: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 timer_output_pin == ($past(ctl_ff.output_pin_function)
         ? ($past(status_ff) ^ $past(ctl_ff.output_invert)) : $past(ctl_ff.output_pin_level)))
      else $error("output pin does not follow its selected source");

   c_pulse_hit:  cover property (@(posedge clk) disable iff (!rst_n)
      !ctl_ff.clock_pulse_mode && hit && ctl_ff.count_run ##1 status_ff);
   c_clock_flip: cover property (@(posedge clk) disable iff (!rst_n)
      ctl_ff.clock_pulse_mode && hit && cnt_en ##1 status_ff);
   c_overflow:   cover property (@(posedge clk) disable iff (!rst_n)
      adv && count_ff == 32'hFFFF_FFFF);
endmodule
`default_nettype wire

// File: core/gpit_pkg.sv
// Package with register indices, control field positions and shared types of the interval timer.
package gpit_pkg;

   localparam logic [1:0] REG_CTL = 2'h0;
   localparam logic [1:0] REG_PRD = 2'h1;
   localparam logic [1:0] REG_CNT = 2'h2;

   localparam int BIT_OUTPUT_PIN_FUNCTION   = 0;
   localparam int BIT_OUTPUT_INVERT = 1;
   localparam int BIT_OUTPUT_PIN_LEVEL = 2;
   localparam int BIT_INPUT_PIN_LEVEL  = 3;
   localparam int BIT_PULSE_WIDTH_SELECT   = 4;
   localparam int BIT_GO     = 6;
   localparam int BIT_HLD    = 7;
   localparam int BIT_CP     = 8;
   localparam int BIT_CLOCK_SOURCE_SELECT = 9;
   localparam int BIT_INPUT_INVERT = 10;
   localparam int BIT_TIMER_STATUS_SIGNAL  = 11;

   localparam logic [31:0] PRD_RESET = 32'h0000_0000;
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
   localparam int          INT_DIV   = 4;

   typedef struct packed {
      logic input_invert;
      logic clock_source_select;
      logic clock_pulse_mode;
      logic count_run;
      logic pulse_width_select;
      logic output_pin_level;
      logic output_invert;
      logic output_pin_function;
   } gpit_ctl_s;

   localparam gpit_ctl_s CTL_RESET = '{default: 1'b0};

endpackage

// File: core/gpit_sync.sv
// Three-stage input synchroniser whose output changes once the last two stages agree.
`timescale 1ns/1ns
`default_nettype none
module gpit_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic out_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         out_ff <= s3_ff;
      end
   end

   assign dout = out_ff;
endmodule
`default_nettype wire

// File: core/gpit_div.sv
// Free-running divider that makes the internal timer input clock as a square-wave level.
`timescale 1ns/1ns
`default_nettype none
module gpit_div #(
   parameter int DIV = 4
) (
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      lvl
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   localparam logic [W-1:0] HALF = W'(DIV / 2);

   logic [W-1:0] cnt_ff;
   logic         lvl_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (cnt_ff == LAST) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_ff <= 1'b0;
      end else begin
         lvl_ff <= (cnt_ff < HALF);
      end
   end

   assign lvl = lvl_ff;
endmodule
`default_nettype wire

// File: test/gpit_pin_src.sv
// Model of the external signal source that drives the timer input pin.
`timescale 1ns/1ns
`default_nettype none
module gpit_pin_src (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       en,
   input  wire logic       lvl,
   input  wire logic [7:0] half,
   output logic            pin
);
   logic [7:0] cnt_ff;
   logic       tog_ff;

   // While disabled the pin shows a plain level, otherwise a square wave of two half periods.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 8'h00;
         tog_ff <= 1'b0;
      end else if (!en) begin
         cnt_ff <= 8'h00;
         tog_ff <= lvl;
      end else if (cnt_ff == half - 8'h01) begin
         cnt_ff <= 8'h00;
         tog_ff <= ~tog_ff;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   assign pin = tog_ff;
endmodule
`default_nettype wire

// File: test/gpit_timer_bench.sv
// Self-checking bench of the interval timer with random register traffic and pulse timing.
`timescale 1ns/1ns
`default_nettype none
module gpit_timer_bench;
   localparam int DIV = 4;
   logic        clk;
   logic        rst_n;
   logic [1:0]  reg_sel;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        timer_input_pin;
   logic        timer_output_pin;
   logic        timer_irq;
   logic        timer_dma_evt;
   logic        emu_halt;
   logic        src_en;
   logic        src_lvl;
   logic [31:0] seed;
   logic [31:0] rv;
   logic [31:0] ev;
   int          error_cnt;
   int          check_count;
   int          cyc;
   int          hi;
   int          per;
   int          p;

   gpit_timer #(.DIV(DIV), .HALT_SUPPORT(1'b1)) gpit_timer_inst (
      .clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_input_pin(timer_input_pin),
      .timer_output_pin(timer_output_pin), .timer_irq(timer_irq),
      .timer_dma_evt(timer_dma_evt), .emu_halt(emu_halt));

   gpit_pin_src gpit_pin_src_inst (
      .clk(clk), .rst_n(rst_n), .en(src_en), .lvl(src_lvl), .half(8'h05),
      .pin(timer_input_pin));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic stop_test();
      if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [1:0] sel, input logic [31:0] d);
      @(posedge clk) #1;
      reg_sel = sel;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk) #1;
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [1:0] sel, output logic [31:0] d);
      @(posedge clk) #1;
      reg_sel = sel;
      reg_rd = 1'b1;
      @(posedge clk) #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   task automatic start(input int pv, input logic [31:0] c);
      wr(gpit_pkg::REG_CTL, c);
      wr(gpit_pkg::REG_PRD, 32'(pv));
      wr(gpit_pkg::REG_CTL, c | 32'h0000_00C0);
      rd(gpit_pkg::REG_CTL, rv);
      chk({31'h0, rv[6]}, 32'h0);
   endtask

   // Waits for a rising status edge, then counts the high phase and the whole period.
   task automatic meas(output int h, output int pr);
      int n;
      n = 0;
      while (timer_irq !== 1'b0 && n < 3000) begin @(negedge clk); n++; end
      while (timer_irq !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
      h = 0;
      while (timer_irq === 1'b1 && n < 3000) begin @(negedge clk); h++; n++; end
      pr = h;
      while (timer_irq !== 1'b1 && n < 3000) begin @(negedge clk); pr++; n++; end
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end

   initial begin
      {reg_sel, reg_wr, reg_rd, reg_wdata, emu_halt, src_en, src_lvl} = '0;
      {seed, error_cnt, check_count, cyc, rst_n} = {32'h1, 32'h0, 32'h0, 32'h0, 1'b0};
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(2'(i), rv);
         chk(rv, 32'h0);
      end
      chk({30'h0, timer_output_pin, timer_irq}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         ev = xs();
         wr(gpit_pkg::REG_PRD, ev);
         wr(gpit_pkg::REG_CNT, ~ev);
         wr(2'h3, xs());
         rd(gpit_pkg::REG_PRD, rv);
         chk(rv, ev);
         rd(gpit_pkg::REG_CNT, rv);
         chk(rv, ~ev);
         rd(2'h3, rv);
         chk(rv, 32'h0);
      end
      for (int m = 0; m < 3; m++) begin
         p = 3 + int'(xs() & 32'h0000_0003);
         start(p, (m == 0) ? 32'h0000_0200 : (m == 1) ? 32'h0000_0210 : 32'h0000_0300);
         meas(hi, per);
         chk(32'(hi), (m == 2) ? 32'(p * DIV) : 32'((m + 1) * DIV));
         chk(32'(per), (m == 2) ? 32'(2 * p * DIV) : 32'(p * DIV));
         chk({31'h0, timer_dma_evt}, {31'h0, timer_irq});
      end
      start(1, 32'h0000_0200);
      repeat (4 * DIV) @(posedge clk);
      hi = 0;
      repeat (40) begin @(negedge clk); hi += (timer_irq === 1'b1) ? 0 : 1; end
      chk(32'(hi), 32'h0);
      start(0, 32'h0000_0300);
      @(negedge clk) ev = {31'h0, timer_irq};
      @(negedge clk) chk({31'h0, timer_irq}, {31'h0, ~ev[0]});
      wr(gpit_pkg::REG_CTL, 32'h0000_0283);
      repeat (3) @(posedge clk);
      chk({31'h0, timer_output_pin}, 32'h0);
      wr(gpit_pkg::REG_CTL, 32'h0000_0284);
      repeat (3) @(posedge clk);
      chk({31'h0, timer_output_pin}, 32'h1);
      start(50, 32'h0000_0200);
      repeat (20) @(posedge clk);
      wr(gpit_pkg::REG_CTL, 32'h0000_0200);
      rd(gpit_pkg::REG_CNT, ev);
      repeat (20) @(posedge clk);
      rd(gpit_pkg::REG_CNT, rv);
      chk(rv, ev);
      wr(gpit_pkg::REG_CTL, 32'h0000_0280);
      emu_halt = 1'b1;
      repeat (3) @(posedge clk);
      rd(gpit_pkg::REG_CNT, ev);
      repeat (20) @(posedge clk);
      rd(gpit_pkg::REG_CNT, rv);
      chk(rv, ev);
      emu_halt = 1'b0;
      repeat (12) @(posedge clk);
      rd(gpit_pkg::REG_CNT, rv);
      chk({31'h0, rv > ev}, 32'h1);
      wr(gpit_pkg::REG_CTL, 32'h0000_0200);
      wr(gpit_pkg::REG_PRD, 32'h0000_0005);
      wr(gpit_pkg::REG_CNT, 32'hFFFF_FFF0);
      wr(gpit_pkg::REG_CTL, 32'h0000_0280);
      repeat (8 * DIV) @(posedge clk);
      rd(gpit_pkg::REG_CNT, rv);
      chk({4'h0, rv[31:4]}, 32'h0FFF_FFFF);
      repeat (12 * DIV) @(posedge clk);
      rd(gpit_pkg::REG_CNT, rv);
      chk({31'h0, rv <= 32'h0000_0005}, 32'h1);
      for (int l = 1; l >= 0; l--) begin
         src_lvl = l[0];
         repeat (8) @(posedge clk);
         rd(gpit_pkg::REG_CTL, rv);
         chk({31'h0, rv[3]}, 32'(l));
      end
      src_en = 1'b1;
      for (int v = 0; v < 2; v++) begin
         start(3, (v == 1) ? 32'h0000_0400 : 32'h0000_0000);
         meas(hi, per);
         chk(32'(per), 32'h0000_001E);
      end
      emu_halt = 1'b1;
      meas(hi, per);
      chk(32'(per), 32'h0000_001E);
      stop_test();
   end
endmodule
`default_nettype wire
